// *** hw/tif_pkg.sv ***
// constants for the timer flag and register slice
package tif_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] OFF_MATCH_IRQ_EN = 8'h14;
  localparam logic [7:0] OFF_MATCH_VALUE_0 = 8'h18;
  localparam logic [7:0] OFF_MATCH_VALUE_1 = 8'h1C;
  localparam logic [7:0] OFF_MATCH_VALUE_2 = 8'h20;
  localparam logic [7:0] OFF_MATCH_VALUE_3 = 8'h24;
  localparam logic [7:0] OFF_CAPTURE_EDGE_CONTROL = 8'h28;
  localparam logic [7:0] OFF_CAPTURE_VALUE = 8'h2C;
  localparam logic [7:0] OFF_MATCH_PIN_CONTROL = 8'h3C;
  localparam logic [7:0] OFF_COUNT_SOURCE_CONTROL = 8'h70;
  localparam logic [7:0] OFF_PULSE_WIDTH_ENABLE = 8'h74;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h80;

  // field widths and positions
  localparam int NUM_MATCH = 4;
  localparam int FLAG_W = 5;
  localparam int FLAG_CAPTURE_BIT = 4;
  localparam int COUNT_W = 16;
  localparam int MATCH_IE_STRIDE = 3;
  localparam int CAP_RISE_BIT = 0;
  localparam int CAP_FALL_BIT = 1;
  localparam int CAP_IRQ_BIT = 2;
  localparam int CAP_W = 3;
  localparam int PIN_W = 12;
  localparam int SRC_W = 4;
  localparam int PWM_W = 2;

  // values after reset
  localparam logic [FLAG_W-1:0] RST_FLAGS = 5'h00;
  localparam logic [COUNT_W-1:0] RST_COUNT = 16'h0000;
  localparam logic [CAP_W-1:0] RST_CAP = 3'h0;
  localparam logic [PIN_W-1:0] RST_PIN = 12'h000;
  localparam logic [SRC_W-1:0] RST_SRC = 4'h0;
  localparam logic [PWM_W-1:0] RST_PWM = 2'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // synchroniser depth at the capture pin
  localparam int SYNC_STAGES = 3;

  // ahb transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;
endpackage

// *** hw/tif_pin_sync.sv ***
// three stage pin synchroniser with edge detection
`timescale 1ns/1ps
module tif_pin_sync (
  input wire logic hclk, // peripheral clock
  input wire logic hresetn, // async reset, active low
  input wire logic pin, // raw pin level
  output logic level, // filtered pin level
  output logic rise, // one-cycle pulse on rising edge
  output logic fall // one-cycle pulse on falling edge
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
    logic rise;
    logic fall;
  } tif_sync_state_type;

  tif_sync_state_type s;
  tif_sync_state_type next_s;

  // stage 0 feeds stage 1 only; a change counts when stages 1 and 2 agree
  always_comb begin
    next_s = s;
    next_s.stage = {s.stage[1:0], pin};
    next_s.rise = 1'b0;
    next_s.fall = 1'b0;
    if (s.stage[1] == s.stage[2] && s.stage[2] != s.level) begin
      next_s.level = s.stage[2];
      next_s.rise = s.stage[2];
      next_s.fall = ~s.stage[2];
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;
  assign rise = s.rise;
  assign fall = s.fall;
endmodule

// *** hw/tif_timer_flags.sv ***
// interrupt flags and control registers of the 16-bit timer, ahb-lite slave
`timescale 1ns/1ps
module tif_timer_flags (
  input wire logic hclk, // peripheral clock, 50 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, words only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready, low in reset, high from the first clock after
  output logic hresp, // response, always okay
  input wire logic [15:0] timer_count, // running count, same clock
  input wire logic capture_in_pin, // capture pin, asynchronous
  output logic [1:0] match_out_pins, // external match pin states
  output logic [1:0] pulse_width_out, // pwm enable per match pin
  output logic [11:0] match_function, // whole match pin control word
  output logic [3:0] count_source, // timer/counter mode and source
  output logic [4:0] event_flags_out, // current flag bits
  output logic irq // level interrupt request
);
  typedef struct packed {
    logic [tif_pkg::FLAG_W-1:0] flags;
    logic [tif_pkg::FLAG_W-1:0] mask;
    logic [tif_pkg::NUM_MATCH-1:0] match_ie;
    logic [tif_pkg::NUM_MATCH-1:0][tif_pkg::COUNT_W-1:0] match_value;
    logic [tif_pkg::CAP_W-1:0] capture_edge_control;
    logic [tif_pkg::COUNT_W-1:0] capture_value;
    logic [tif_pkg::PIN_W-1:0] match_pin_control;
    logic [tif_pkg::SRC_W-1:0] count_source_control;
    logic [tif_pkg::PWM_W-1:0] pulse_width_enable;
    logic [7:0] dp_addr;
    logic dp_write;
    logic [31:0] hrdata;
    logic hreadyout;
    logic irq;
  } tif_state_type;

  tif_state_type s;
  tif_state_type next_s;

  logic cap_level;
  logic cap_rise;
  logic cap_fall;

  // capture pin comes from outside the clock domain
  tif_pin_sync u_cap_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(capture_in_pin),
    .level(cap_level),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  // word readback of a register file snapshot; unmapped reads give zero
  function automatic logic [31:0] read_word(input tif_state_type r,
                                            input logic [7:0] addr);
    logic [31:0] w;
    w = tif_pkg::RST_WORD;
    case (addr)
      tif_pkg::OFF_EVENT_FLAGS: begin
        w[tif_pkg::FLAG_W-1:0] = r.flags;
      end
      tif_pkg::OFF_IRQ_MASK: begin
        w[tif_pkg::FLAG_W-1:0] = r.mask;
      end
      tif_pkg::OFF_MATCH_IRQ_EN: begin
        for (int i = 0; i < tif_pkg::NUM_MATCH; i++) begin
          w[i*tif_pkg::MATCH_IE_STRIDE] = r.match_ie[i];
        end
      end
      tif_pkg::OFF_MATCH_VALUE_0: begin
        w[tif_pkg::COUNT_W-1:0] = r.match_value[0];
      end
      tif_pkg::OFF_MATCH_VALUE_1: begin
        w[tif_pkg::COUNT_W-1:0] = r.match_value[1];
      end
      tif_pkg::OFF_MATCH_VALUE_2: begin
        w[tif_pkg::COUNT_W-1:0] = r.match_value[2];
      end
      tif_pkg::OFF_MATCH_VALUE_3: begin
        w[tif_pkg::COUNT_W-1:0] = r.match_value[3];
      end
      tif_pkg::OFF_CAPTURE_EDGE_CONTROL: begin
        w[tif_pkg::CAP_W-1:0] = r.capture_edge_control;
      end
      tif_pkg::OFF_CAPTURE_VALUE: begin
        w[tif_pkg::COUNT_W-1:0] = r.capture_value;
      end
      tif_pkg::OFF_MATCH_PIN_CONTROL: begin
        w[tif_pkg::PIN_W-1:0] = r.match_pin_control;
      end
      tif_pkg::OFF_COUNT_SOURCE_CONTROL: begin
        w[tif_pkg::SRC_W-1:0] = r.count_source_control;
      end
      tif_pkg::OFF_PULSE_WIDTH_ENABLE: begin
        w[tif_pkg::PWM_W-1:0] = r.pulse_width_enable;
      end
      default: begin
        w = tif_pkg::RST_WORD;
      end
    endcase
    return w;
  endfunction

  // next state: data phase write, events, then address phase read
  always_comb begin
    logic [tif_pkg::FLAG_W-1:0] evt;
    logic [tif_pkg::FLAG_W-1:0] clr;
    logic cap_evt;
    logic addr_phase;
    evt = '0;
    clr = '0;
    cap_evt = 1'b0;
    addr_phase = 1'b0;
    next_s = s;
    next_s.hreadyout = 1'b1;
    next_s.dp_write = 1'b0;

    // data phase of a write taken in the previous cycle
    if (s.dp_write) begin
      case (s.dp_addr)
        tif_pkg::OFF_EVENT_FLAGS: begin
          clr = hwdata[tif_pkg::FLAG_W-1:0];
        end
        tif_pkg::OFF_IRQ_MASK: begin
          next_s.mask = hwdata[tif_pkg::FLAG_W-1:0];
        end
        tif_pkg::OFF_MATCH_IRQ_EN: begin
          for (int i = 0; i < tif_pkg::NUM_MATCH; i++) begin
            next_s.match_ie[i] = hwdata[i*tif_pkg::MATCH_IE_STRIDE];
          end
        end
        tif_pkg::OFF_MATCH_VALUE_0: begin
          next_s.match_value[0] = hwdata[tif_pkg::COUNT_W-1:0];
        end
        tif_pkg::OFF_MATCH_VALUE_1: begin
          next_s.match_value[1] = hwdata[tif_pkg::COUNT_W-1:0];
        end
        tif_pkg::OFF_MATCH_VALUE_2: begin
          next_s.match_value[2] = hwdata[tif_pkg::COUNT_W-1:0];
        end
        tif_pkg::OFF_MATCH_VALUE_3: begin
          next_s.match_value[3] = hwdata[tif_pkg::COUNT_W-1:0];
        end
        tif_pkg::OFF_CAPTURE_EDGE_CONTROL: begin
          next_s.capture_edge_control = hwdata[tif_pkg::CAP_W-1:0];
        end
        tif_pkg::OFF_MATCH_PIN_CONTROL: begin
          next_s.match_pin_control = hwdata[tif_pkg::PIN_W-1:0];
        end
        tif_pkg::OFF_COUNT_SOURCE_CONTROL: begin
          next_s.count_source_control = hwdata[tif_pkg::SRC_W-1:0];
        end
        tif_pkg::OFF_PULSE_WIDTH_ENABLE: begin
          next_s.pulse_width_enable = hwdata[tif_pkg::PWM_W-1:0];
        end
        default: begin
          // capture value and unmapped words ignore writes
          clr = '0;
        end
      endcase
    end

    // match events while the count equals an enabled match value
    for (int i = 0; i < tif_pkg::NUM_MATCH; i++) begin
      evt[i] = s.match_ie[i] &&
               (timer_count == s.match_value[i]);
    end

    // capture on the selected pin edges loads the count
    cap_evt = (cap_rise && s.capture_edge_control[tif_pkg::CAP_RISE_BIT]) ||
              (cap_fall && s.capture_edge_control[tif_pkg::CAP_FALL_BIT]);
    if (cap_evt) begin
      next_s.capture_value = timer_count;
    end
    evt[tif_pkg::FLAG_CAPTURE_BIT] = cap_evt &&
      s.capture_edge_control[tif_pkg::CAP_IRQ_BIT];

    // sticky flags: set wins so no event is lost under a clear
    next_s.flags = (s.flags & ~clr) | evt;

    // interrupt level follows the flags that will stand next cycle
    next_s.irq = |(next_s.flags & next_s.mask);

    // address phase: remember writes, answer reads a cycle later
    addr_phase = hsel && hready && htrans[tif_pkg::HTRANS_ACTIVE_BIT];
    if (addr_phase) begin
      next_s.dp_addr = haddr[7:0];
      next_s.dp_write = hwrite;
      if (!hwrite) begin
        // reading the post-write view keeps read-after-write coherent
        next_s.hrdata = read_word(next_s, haddr[7:0]);
      end
    end
  end

  // one register for the whole state; reset clears every field
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register, except hresp, which is tied to okay
  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = tif_pkg::HRESP_OKAY;
  assign match_out_pins = s.match_pin_control[1:0];
  assign pulse_width_out = s.pulse_width_enable;
  assign match_function = s.match_pin_control;
  assign count_source = s.count_source_control;
  assign event_flags_out = s.flags;
  assign irq = s.irq;
endmodule

// *** bench/tif_timer_flags_asserts.sv ***
// port assertions for the timer flag slice
`timescale 1ns/1ps
module tif_timer_flags_asserts (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, low
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // type
  input wire logic hwrite, // write
  input wire logic [31:0] hwdata, // wdata
  input wire logic hready, // ready in
  input wire logic capture_in_pin, // capture pin
  input wire logic [1:0] match_out_pins, // pins
  input wire logic [1:0] pulse_width_out, // pwm
  input wire logic [11:0] match_function, // pin control
  input wire logic [3:0] count_source, // source
  input wire logic [4:0] event_flags_out, // flags
  input wire logic irq // request
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic flag_wr_q; // data phase of a flag write
  // address phase taken, then its data phase
  sequence wr_s(logic [7:0] off);
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == off ##1 hready;
  endsequence
  // remember flag writes so a falling bit can be traced to its cause
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_wr_q <= 1'b0;
    end else begin
      flag_wr_q <= hsel && hready && htrans[1] && hwrite &&
        haddr[7:0] == tif_pkg::OFF_EVENT_FLAGS;
    end
  end
  flag_clear_a: assert property (
    ($past(event_flags_out) & ~event_flags_out) != 5'h00 |->
      $past(flag_wr_q) && ($past(event_flags_out) & ~event_flags_out &
      ~$past(hwdata[4:0])) == 5'h00)
    else $error("flag fell without a one written");
  irq_flag_a: assert property (irq |-> event_flags_out != 5'h00)
    else $error("irq high with no flag set");
  pins_follow_a: assert property (
    match_out_pins == match_function[1:0])
    else $error("match pins differ from pin control");
  pwm_write_a: assert property (
    wr_s(tif_pkg::OFF_PULSE_WIDTH_ENABLE) |=>
      pulse_width_out == $past(hwdata[1:0]))
    else $error("pwm enable not written");
  count_write_a: assert property (
    wr_s(tif_pkg::OFF_COUNT_SOURCE_CONTROL) |=>
      count_source == $past(hwdata[3:0]))
    else $error("count source not written");
  pin_ctl_write_a: assert property (
    wr_s(tif_pkg::OFF_MATCH_PIN_CONTROL) |=>
      match_function == $past(hwdata[11:0]))
    else $error("match pin control not written");
  reset_zero_a: assert property (!$past(hresetn) |->
    {event_flags_out, count_source, match_function, pulse_width_out,
      irq} == 24'h000000)
    else $error("output not zero after reset");
  capture_cause_a: assert property (
    $rose(event_flags_out[4]) |->
      $past(capture_in_pin, 1) != $past(capture_in_pin, 10))
    else $error("capture flag without pin edge");
endmodule

bind tif_timer_flags tif_timer_flags_asserts tif_timer_flags_asserts_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .capture_in_pin(capture_in_pin), .match_out_pins(match_out_pins),
  .pulse_width_out(pulse_width_out), .match_function(match_function),
  .count_source(count_source), .event_flags_out(event_flags_out),
  .irq(irq));

// *** bench/tb.sv ***
// self-checking bench for the timer flag slice
`timescale 1ns/1ps
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] timer_count = 16'hFFFF;
  logic capture_in_pin = 1'b0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, irq;
  logic [1:0] match_out_pins, pulse_width_out;
  logic [11:0] match_function;
  logic [3:0] count_source;
  logic [4:0] event_flags_out, ef;
  logic [15:0] seed = 16'h0056;
  logic [15:0] mv [4];
  logic [31:0] wv [4];
  // reset table ends with one unmapped word
  logic [7:0] roff [7] = '{8'h00, 8'h28, 8'h2C, 8'h3C, 8'h70, 8'h74, 8'h40};
  logic [7:0] woff [4] = '{8'h28, 8'h3C, 8'h70, 8'h74};
  logic [31:0] wmsk [4] = '{32'h7, 32'hFFF, 32'hF, 32'h3};
  int err_count = 0;
  int n_tests = 0;
  always #10 hclk = ~hclk;
  tif_timer_flags tif_timer_flags_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_count(timer_count),
    .capture_in_pin(capture_in_pin), .match_out_pins(match_out_pins),
    .pulse_width_out(pulse_width_out), .match_function(match_function),
    .count_source(count_source), .event_flags_out(event_flags_out),
    .irq(irq));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input string n, input logic [31:0] e, got);
    n_tests++;
    if (got !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, got);
    end
  endtask
  // one single transfer; read data is taken at the end of the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_is(input string n, input logic [7:0] a, input [31:0] e);
    bus(1'b0, a, 32'h0);
    check(n, e, rd);
  endtask
  // look at the flags away from the edge, then return on a rising edge
  // so the next drive still lands right after a clock edge
  task automatic flags_are(input logic [4:0] e, input logic q);
    @(negedge hclk);
    check("flags", 32'(e), 32'(event_flags_out));
    check("irq", 32'(q), 32'(irq));
    @(posedge hclk);
  endtask
  // pulse the count onto one match value for a single cycle
  task automatic hit(input int i);
    timer_count <= mv[i];
    @(posedge hclk);
    timer_count <= 16'hFFFF;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge hclk);
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (roff[k]) rd_is("reset", roff[k], 32'h0);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      wv[k] = {seed, ~seed};
      bus(1'b1, woff[k], wv[k]);
      rd_is("control", woff[k], wv[k] & wmsk[k]);
    end
    check("match ctl", wv[1] & 32'hFFF, 32'(match_function));
    check("pins", wv[1] & 32'h3, 32'(match_out_pins));
    check("source", wv[2] & 32'hF, 32'(count_source));
    check("pwm", wv[3] & 32'h3, 32'(pulse_width_out));
    bus(1'b1, tif_pkg::OFF_CAPTURE_VALUE, wv[0]);
    rd_is("capture ro", tif_pkg::OFF_CAPTURE_VALUE, 32'h0);
    check("ro resp", 32'h0, 32'(hresp));
    check("ro ready", 32'h1, 32'(hreadyout));
    bus(1'b1, tif_pkg::OFF_IRQ_MASK, 32'h1F);
    // distinct low bits keep the four match values apart
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      mv[i] = {1'b0, seed[14:2], 2'(i)};
      bus(1'b1, tif_pkg::OFF_MATCH_VALUE_0 + 8'(4 * i), 32'(mv[i]));
    end
    bus(1'b1, tif_pkg::OFF_MATCH_IRQ_EN, 32'h249);
    ef = 5'h00;
    for (int i = 0; i < 4; i++) begin
      hit(i);
      ef[i] = 1'b1;
      flags_are(ef, 1'b1);
    end
    bus(1'b1, tif_pkg::OFF_EVENT_FLAGS, 32'h0);
    flags_are(5'h0F, 1'b1);
    bus(1'b1, tif_pkg::OFF_EVENT_FLAGS, 32'h5);
    flags_are(5'h0A, 1'b1);
    bus(1'b1, tif_pkg::OFF_EVENT_FLAGS, 32'hA);
    flags_are(5'h00, 1'b0);
    bus(1'b1, tif_pkg::OFF_IRQ_MASK, 32'h0);
    hit(2);
    flags_are(5'h04, 1'b0);
    bus(1'b1, tif_pkg::OFF_IRQ_MASK, 32'h1F);
    // event lands in the same cycle as the clear of its flag
    timer_count <= mv[2];
    bus(1'b1, tif_pkg::OFF_EVENT_FLAGS, 32'h4);
    timer_count <= 16'hFFFF;
    flags_are(5'h04, 1'b1);
    bus(1'b1, tif_pkg::OFF_EVENT_FLAGS, 32'h1F);
    flags_are(5'h00, 1'b0);
    bus(1'b1, tif_pkg::OFF_MATCH_IRQ_EN, 32'h0);
    bus(1'b1, tif_pkg::OFF_CAPTURE_EDGE_CONTROL, 32'h5);
    seed = lfsr(seed);
    timer_count <= seed;
    capture_in_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    flags_are(5'h10, 1'b1);
    rd_is("capture", tif_pkg::OFF_CAPTURE_VALUE, 32'(seed));
    timer_count <= ~seed;
    capture_in_pin <= 1'b0;
    repeat (8) @(posedge hclk);
    rd_is("no fall", tif_pkg::OFF_CAPTURE_VALUE, 32'(seed));
    bus(1'b1, tif_pkg::OFF_EVENT_FLAGS, 32'h10);
    bus(1'b1, tif_pkg::OFF_CAPTURE_EDGE_CONTROL, 32'h2);
    capture_in_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    capture_in_pin <= 1'b0;
    repeat (8) @(posedge hclk);
    flags_are(5'h00, 1'b0);
    rd_is("fall", tif_pkg::OFF_CAPTURE_VALUE, {16'h0000, ~seed});
    print_verdict();
  end
endmodule
